// file: bench/nlex_checker.sv
`timescale 1ns/1ps
module nlex_checker (
   input wire logic        CLOCK,
   input wire logic        SRST,
   input wire logic        ISSUE_VALID,
   input wire logic        ISSUE_READY,
   input wire logic [31:0] ISSUE_INSN,
   input wire logic [31:0] ISSUE_BASE_VALUE,
   input wire logic        MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic [3:0]  MEM_BE,
   input wire logic        MEM_RVALID,
   input wire logic [31:0] MEM_RDATA,
   input wire logic [31:0] WB_DATA,
   input wire logic        DECODE_MISS
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SRST);
   logic        tk, ld;
   logic [3:0]  mn, mq;
   logic [1:0]  lq;
   logic [31:0] ea, sb;
   assign tk = ISSUE_VALID && ISSUE_READY;
   assign mn = ISSUE_INSN[15:12];
   assign ld = tk && ISSUE_INSN[31:28] == 4'h2 && mn inside {4'h0, 4'h4, 4'h1};
   assign ea = ISSUE_BASE_VALUE + {{20{ISSUE_INSN[11]}}, ISSUE_INSN[11:0]};
   assign sb = MEM_RDATA >> {lq, 3'h0};
   // the bus echoes neither variant nor lane, so keep them from the take
   always_ff @(posedge CLOCK) if (tk) {mq, lq} <= {mn, ea[1], ea[0] && mn != 4'h1};
   AST_MISS: assert property (tk && ISSUE_INSN[31:28] != 4'h2 |=> DECODE_MISS && !MEM_REQ)
      else $error("miss");
   AST_ADDR: assert property (ld |=> MEM_ADDR == {$past(ea[31:2]), 2'h0})
      else $error("addr");
   AST_LANE: assert property (ld && mn != 4'h1 |=> MEM_BE == 4'h1 << $past(ea[1:0]))
      else $error("lane");
   AST_HALF: assert property (ld && mn == 4'h1 |=> MEM_BE == ($past(ea[1]) ? 4'hc : 4'h3))
      else $error("half");
   AST_HOLD: assert property (MEM_REQ && !MEM_RVALID |=>
      MEM_REQ && $stable({MEM_ADDR, MEM_BE})) else $error("hold");
   AST_SBYTE: assert property (MEM_RVALID && mq == 4'h0 |=>
      WB_DATA == {{24{$past(sb[7])}}, $past(sb[7:0])}) else $error("sbyte");
   AST_UBYTE: assert property (MEM_RVALID && mq == 4'h4 |=>
      WB_DATA == {24'h0, $past(sb[7:0])}) else $error("ubyte");
   AST_SHALF: assert property (MEM_RVALID && mq == 4'h1 |=>
      WB_DATA == {{16{$past(sb[15])}}, $past(sb[15:0])}) else $error("shalf");
   AST_MINOR: assert property (tk && !ld && ISSUE_INSN[31:28] == 4'h2 |=>
      DECODE_MISS && !MEM_REQ) else $error("minor");
   AST_REQ: assert property (ld |=> MEM_REQ && !DECODE_MISS && !ISSUE_READY)
      else $error("req");
endmodule
bind nlex_top nlex_checker i_nlex_checker (.*);

// file: bench/nlex_mem_model.sv
`timescale 1ns/1ps
module nlex_mem_model (
   input  wire logic        clock,
   input  wire logic        mem_req,
   input  wire logic [3:0]  dly,
   input  wire logic [31:0] pat,
   output      logic        rvalid,
   output      logic [31:0] rdata
);
   logic [3:0] cnt = 4'h0;
   assign rvalid = mem_req && cnt == dly;
   // inverse outside the answer, so stale data cannot pass
   assign rdata = rvalid ? pat : ~pat;
   always @(posedge clock) cnt <= mem_req && !rvalid ? cnt + 4'h1 : 4'h0;
endmodule

// file: bench/nlex_tb_top.sv
`timescale 1ns/1ps
module nlex_tb_top;
   logic        clk = 1'b0, rst = 1'b1, iv = 1'b0, rv, rdy, req, wbv, miss;
   logic [3:0]  dly = 4'h0;
   logic [5:0]  wreg, bidx;
   logic [31:0] insn = 32'h0, base = 32'h0, rd, wd, pat = 32'h80f1_7f2e;
   int          error_cnt = 0, num_checks = 0;
   nlex_top i_nlex_top (.CLOCK(clk), .SRST(rst), .ISSUE_VALID(iv), .ISSUE_READY(rdy),
      .ISSUE_INSN(insn), .ISSUE_BASE_VALUE(base), .ISSUE_BASE_INDEX(bidx), .MEM_REQ(req),
      .MEM_ADDR(), .MEM_BE(), .MEM_RVALID(rv), .MEM_RDATA(rd), .WB_VALID(wbv),
      .WB_REG(wreg), .WB_DATA(wd), .DECODE_MISS(miss));
   nlex_mem_model i_nlex_mem_model (.clock(clk), .mem_req(req), .dly(dly), .pat(pat),
      .rvalid(rv), .rdata(rd));
   initial forever #4 clk = ~clk;
   task conclude;
      if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(string n, logic [31:0] e, s);
      num_checks++;
      if (e !== s) error_cnt++;
      if (e !== s) $display("wrong value %s expected %h seen %h", n, e, s);
   endtask
   task ld(logic [3:0] m, logic [31:0] b, logic [11:0] o, logic [31:0] e);
      int i;
      @(negedge clk);
      chk("ready", 32'h1, {31'h0, rdy});
      {iv, base, insn} = {1'b1, b, 4'h2, 6'h05, 6'h0b, m, o};
      @(negedge clk);
      iv = 1'b0;
      chk("base_index", 32'h05, {26'h0, bidx});
      chk("busy", 32'h0, {31'h0, rdy});
      for (i = 0; i < 20 && wbv !== 1'b1; i++) @(negedge clk);
      chk("wb_valid", 32'h1, {31'h0, wbv});
      if (i == 20) conclude();
      chk("wb_data", e, wd);
      chk("wb_reg", 32'h0b, {26'h0, wreg});
      @(negedge clk);
      chk("wb_pulse", 32'h0, {31'h0, wbv});
   endtask
   task sc_bytes;
      for (int l = 0; l < 4; l++) ld(4'h0, 32'h100, 12'hffc + 12'(l),
         {{24{pat[8*l+7]}}, pat[8*l+:8]});
      dly = 4'h3;
      for (int l = 0; l < 4; l++) ld(4'h4, 32'hf000_0000, 12'(l),
         {24'h0, pat[8*l+:8]});
   endtask
   task sc_half;
      dly = 4'h1;
      ld(4'h1, 32'h2, 12'hffe, 32'h0000_7f2e);
      ld(4'h1, 32'h2, 12'h000, 32'hffff_80f1);
   endtask
   task sc_miss;
      @(negedge clk);
      {iv, insn} = {1'b1, 32'h3000_0000};
      @(negedge clk);
      iv = 1'b0;
      chk("miss", 32'h1, {31'h0, miss & ~req});
      @(negedge clk);
      // right major opcode, unknown minor: still consumed as a miss
      {iv, insn} = {1'b1, 32'h2000_2000};
      @(negedge clk);
      iv = 1'b0;
      chk("minor_miss", 32'h1, {31'h0, miss & ~req});
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      sc_bytes();
      sc_half();
      sc_miss();
      conclude();
   end
endmodule

// file: core/nlex_ext_if.sv
`timescale 1ns/1ps
interface nlex_ext_if;
   logic [31:0]         word;
   logic [1:0]          lane;
   nlex_pkg::nlex_mode_t mode;
   logic [31:0]         result;
   modport drv (output word, output lane, output mode, input result);
   modport ext (input word, input lane, input mode, output result);
endinterface

// file: core/nlex_extend.sv
`timescale 1ns/1ps
module nlex_extend (
   nlex_ext_if.ext x
);
   logic [7:0]  byte_v;
   logic [15:0] half_v;

   always_comb begin
      // lane picked from the low address bits, no alignment demanded
      byte_v = x.word[8 * x.lane +: 8]; // RL10
      // bit 0 ignored; odd halfword addresses give an undefined lane anyway
      half_v = x.lane[1] ? x.word[31:16] : x.word[15:0]; // RL5
      case (x.mode)
         nlex_pkg::NLEX_BYTE_S: x.result = {{24{byte_v[7]}}, byte_v}; // RL2
         nlex_pkg::NLEX_BYTE_U: x.result = {24'h000000, byte_v}; // RL3
         nlex_pkg::NLEX_HALF_S: x.result = {{16{half_v[15]}}, half_v}; // RL4
         default:               x.result = nlex_pkg::ZERO_WORD;
      endcase
   end
endmodule

// file: core/nlex_pkg.sv
// Functional notes
// [RL1] effective address is base value plus sign-extended 12-bit offset
// [RL2] signed byte load: fetched byte sign-extended from 8 to 32 bits
// [RL3] unsigned byte load: fetched byte with upper 24 bits zero
// [RL4] signed halfword load: fetched 16 bits sign-extended to 32 bits
// [RL5] software keeps halfword addresses even; odd result is undefined
// [RL6] base operand is always a general register, never an extension register
// [RL7] loads decode on major opcode 0x2, I-12 layout with five fields
// [RL8] memory and peripheral byte loads use one identical bus access
// [RL9] minor opcode picks signed byte, unsigned byte or signed halfword
// [RL10] byte loads take any address, selecting the lane from the word
package nlex_pkg;
   localparam int unsigned OPC_MSB      = 31;
   localparam int unsigned OPC_LSB      = 28;
   localparam int unsigned BASE_MSB     = 27;
   localparam int unsigned BASE_LSB     = 22;
   localparam int unsigned DEST_MSB     = 21;
   localparam int unsigned DEST_LSB     = 16;
   localparam int unsigned MINOR_MSB    = 15;
   localparam int unsigned MINOR_LSB    = 12;
   localparam int unsigned IMM_MSB      = 11;
   localparam int unsigned IMM_LSB      = 0;
   localparam logic [3:0]  OPC_LOAD     = 4'h2;
   localparam logic [3:0]  MINOR_BYTE_S = 4'h0;
   localparam logic [3:0]  MINOR_BYTE_U = 4'h4;
   localparam logic [3:0]  MINOR_HALF_S = 4'h1;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
   localparam logic [3:0]  BE_NONE      = 4'h0;
   localparam logic [3:0]  BE_BYTE0     = 4'h1;
   localparam logic [3:0]  BE_HALF0     = 4'h3;
   localparam logic [5:0]  REG_NONE     = 6'h00;

   typedef enum logic [1:0] {
      NLEX_BYTE_S = 2'b00,
      NLEX_BYTE_U = 2'b01,
      NLEX_HALF_S = 2'b10
   } nlex_mode_t;

   typedef enum logic [1:0] {
      NLEX_IDLE = 2'b00,
      NLEX_REQ  = 2'b01,
      NLEX_DONE = 2'b10
   } nlex_state_t;

   typedef struct packed {
      nlex_state_t st;
      nlex_mode_t  mode;
      logic [31:0] addr;
      logic [3:0]  be;
      logic [5:0]  dest;
      logic        wb_valid;
      logic [31:0] wb_data;
      logic        miss;
   } nlex_regs_t;
endpackage

// file: core/nlex_top.sv
`timescale 1ns/1ps
module nlex_top (
   input  wire logic        CLOCK,
   input  wire logic        SRST,
   input  wire logic        ISSUE_VALID,
   output      logic        ISSUE_READY,
   input  wire logic [31:0] ISSUE_INSN,
   input  wire logic [31:0] ISSUE_BASE_VALUE,
   output      logic [5:0]  ISSUE_BASE_INDEX,
   output      logic        MEM_REQ,
   output      logic [31:0] MEM_ADDR,
   output      logic [3:0]  MEM_BE,
   input  wire logic        MEM_RVALID,
   input  wire logic [31:0] MEM_RDATA,
   output      logic        WB_VALID,
   output      logic [5:0]  WB_REG,
   output      logic [31:0] WB_DATA,
   output      logic        DECODE_MISS
);
   nlex_pkg::nlex_regs_t r_q;
   nlex_pkg::nlex_regs_t r_d;
   nlex_ext_if           ext ();

   logic [3:0]  opc;
   logic [3:0]  minor;
   logic [11:0] offset_imm_field;
   logic [5:0]  dest_reg_operand;
   logic [31:0] eff_addr;
   logic        is_load;
   nlex_pkg::nlex_mode_t dec_mode;
   logic [3:0]  dec_be;

   assign opc              = ISSUE_INSN[nlex_pkg::OPC_MSB:nlex_pkg::OPC_LSB];
   assign minor            = ISSUE_INSN[nlex_pkg::MINOR_MSB:nlex_pkg::MINOR_LSB];
   assign offset_imm_field = ISSUE_INSN[nlex_pkg::IMM_MSB:nlex_pkg::IMM_LSB];
   assign dest_reg_operand = ISSUE_INSN[nlex_pkg::DEST_MSB:nlex_pkg::DEST_LSB];
   // core reads its general file at this index; extension names never reach here
   assign ISSUE_BASE_INDEX = ISSUE_INSN[nlex_pkg::BASE_MSB:nlex_pkg::BASE_LSB]; // RL6

   assign eff_addr = ISSUE_BASE_VALUE + {{20{offset_imm_field[11]}}, offset_imm_field}; // RL1

   always_comb begin
      is_load  = 1'b0;
      dec_mode = nlex_pkg::NLEX_BYTE_S;
      if (opc == nlex_pkg::OPC_LOAD) begin // RL7
         case (minor) // RL9
            nlex_pkg::MINOR_BYTE_S: begin
               is_load  = 1'b1;
               dec_mode = nlex_pkg::NLEX_BYTE_S;
            end
            nlex_pkg::MINOR_BYTE_U: begin
               is_load  = 1'b1;
               dec_mode = nlex_pkg::NLEX_BYTE_U;
            end
            nlex_pkg::MINOR_HALF_S: begin
               is_load  = 1'b1;
               dec_mode = nlex_pkg::NLEX_HALF_S;
            end
            default: begin
               is_load  = 1'b0;
               dec_mode = nlex_pkg::NLEX_BYTE_S;
            end
         endcase
      end
   end

   always_comb begin
      if (dec_mode == nlex_pkg::NLEX_HALF_S) begin
         dec_be = nlex_pkg::BE_HALF0 << {eff_addr[1], 1'b0};
      end else begin
         dec_be = nlex_pkg::BE_BYTE0 << eff_addr[1:0]; // RL10
      end
   end

   assign ext.word = MEM_RDATA;
   assign ext.lane = r_q.addr[1:0];
   assign ext.mode = r_q.mode;

   nlex_extend u_extend (
      .x (ext.ext)
   );

   always_comb begin
      r_d          = r_q;
      r_d.wb_valid = 1'b0;
      r_d.miss     = 1'b0;
      case (r_q.st)
         nlex_pkg::NLEX_IDLE: begin
            if (ISSUE_VALID) begin
               if (is_load) begin
                  r_d.st   = nlex_pkg::NLEX_REQ;
                  r_d.mode = dec_mode;
                  r_d.addr = eff_addr;
                  r_d.be   = dec_be;
                  r_d.dest = dest_reg_operand;
               end else begin
                  // foreign instructions are consumed and flagged, not stalled on
                  r_d.miss = 1'b1;
               end
            end
         end
         nlex_pkg::NLEX_REQ: begin
            // one access path whatever the target: memory or peripheral
            if (MEM_RVALID) begin // RL8
               r_d.st       = nlex_pkg::NLEX_DONE;
               r_d.wb_valid = 1'b1;
               r_d.wb_data  = ext.result;
            end
         end
         nlex_pkg::NLEX_DONE: begin
            r_d.st = nlex_pkg::NLEX_IDLE;
         end
         default: begin
            r_d.st = nlex_pkg::NLEX_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         r_q.st       <= nlex_pkg::NLEX_IDLE;
         r_q.mode     <= nlex_pkg::NLEX_BYTE_S;
         r_q.addr     <= nlex_pkg::ZERO_WORD;
         r_q.be       <= nlex_pkg::BE_NONE;
         r_q.dest     <= nlex_pkg::REG_NONE;
         r_q.wb_valid <= 1'b0;
         r_q.wb_data  <= nlex_pkg::ZERO_WORD;
         r_q.miss     <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign ISSUE_READY = (r_q.st == nlex_pkg::NLEX_IDLE);
   assign MEM_REQ     = (r_q.st == nlex_pkg::NLEX_REQ);
   // word aligned; the byte enables carry the lane
   assign MEM_ADDR    = {r_q.addr[31:2], 2'b00};
   assign MEM_BE      = r_q.be;
   assign WB_VALID    = r_q.wb_valid;
   assign WB_REG      = r_q.dest;
   assign WB_DATA     = r_q.wb_data;
   assign DECODE_MISS = r_q.miss;
endmodule
